// ===== lwpc_pkg.sv
/*
  Constants and types for the lock window and pump control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package lwpc_pkg;
  // ***************************************************
  // register map
  // ***************************************************
  localparam logic [7:0]  ADDR_LOCK_DETECT_CONTROL = 8'h07;
  localparam logic [7:0]  ADDR_PUMP_GAIN_AND_OFFSET = 8'h09;
  localparam logic [7:0]  ADDR_PHASE_DETECTOR_CONTROL = 8'h0B;
  localparam logic [7:0]  ADDR_LOCK_STATUS = 8'h12;
  localparam logic [23:0] RST_LOCK_DETECT_CONTROL = 24'h000000;
  localparam logic [23:0] RST_PUMP_GAIN_AND_OFFSET = 24'h000000;
  localparam logic [23:0] RST_PHASE_DETECTOR_CONTROL = 24'h000000;
  // ***************************************************
  // field positions
  // ***************************************************
  localparam int LD_COUNT_LSB = 0;
  localparam int LD_ENABLE_BIT = 3;
  localparam int LD_DIGITAL_BIT = 6;
  localparam int LD_DIV_LSB = 7;
  localparam int LD_SPEED_LSB = 10;
  localparam int PG_GAIN_A_LSB = 0;
  localparam int PG_GAIN_B_LSB = 7;
  localparam int PG_OFFSET_LSB = 14;
  localparam int PG_OFFSET_UP_BIT = 21;
  localparam int PG_OFFSET_DN_BIT = 22;
  localparam int PD_POLARITY_BIT = 4;
  localparam int PD_UP_ENABLE_BIT = 5;
  localparam int PD_DN_ENABLE_BIT = 6;
  localparam int PD_SLIP_LSB = 7;
  localparam int STATUS_LOCK_BIT = 1;
  // ***************************************************
  // timing, in clk cycles and ns
  // ***************************************************
  // one-shot periods per speed code, kept even so half a period exists
  localparam logic [3:0] TIMER_PERIOD_0 = 4'h2;
  localparam logic [3:0] TIMER_PERIOD_1 = 4'h4;
  localparam logic [3:0] TIMER_PERIOD_2 = 4'h6;
  localparam logic [3:0] TIMER_PERIOD_3 = 4'h8;
  localparam real ANALOG_WINDOW_NS = 10.0;
  localparam real CLK_PERIOD_NS = 40.0;
  localparam int ANALOG_WINDOW_RAW = int'($floor(ANALOG_WINDOW_NS
                                                  / CLK_PERIOD_NS));
  localparam logic [10:0] ANALOG_WINDOW_CYCLES =
    (ANALOG_WINDOW_RAW < 1) ? 11'h001 : 11'(ANALOG_WINDOW_RAW);
  // lock count code 5 gives 2048 hits: hits = 2^(code + 6)
  localparam int LOCK_COUNT_SHIFT = 6;
  localparam int LOCK_COUNT_W = 14;

  typedef enum logic [1:0] {WIN_IDLE, WIN_REF_FIRST, WIN_DIV_FIRST}
    lwpc_win_t;
endpackage : lwpc_pkg
`default_nettype wire

// ===== lwpc_properties.sv
/* checker for the lwpc_top ports.
   assumes bind into lwpc_top; one clock, reset active low */
`default_nettype none
module lwpc_properties
  import lwpc_pkg::*;
(
  // watched ports
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        ce,
  input wire logic        regWrEn,
  input wire logic [7:0]  regAddr,
  input wire logic [23:0] regWrData,
  input wire logic        refArrive,
  input wire logic        divArrive,
  input wire logic        pdUpRaw,
  input wire logic        pdDnRaw,
  input wire logic        pumpUp,
  input wire logic        pumpDn,
  input wire logic        pumpTriState,
  input wire logic [6:0]  pumpGainA,
  input wire logic [6:0]  pumpGainB,
  input wire logic [6:0]  offsetMagnitude,
  input wire logic        offsetUpEn,
  input wire logic        offsetDnEn,
  input wire logic [1:0]  cycleSlipGuard,
  input wire logic        lockFlag
);
  // ****************************************
  // helpers and properties
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic       w7, w9, wb;
  logic [6:0] arrCnt_reg, arrCnt_next;
  assign w7 = ce && regWrEn && regAddr == ADDR_LOCK_DETECT_CONTROL;
  assign w9 = ce && regWrEn && regAddr == ADDR_PUMP_GAIN_AND_OFFSET;
  assign wb = ce && regWrEn && regAddr == ADDR_PHASE_DETECTOR_CONTROL;
  // arrivals while unlocked, saturating; a hit needs at least one
  always_comb begin
    arrCnt_next = arrCnt_reg;
    if (lockFlag) arrCnt_next = 7'h00;
    else if (ce && (refArrive || divArrive) && !arrCnt_reg[6])
      arrCnt_next = arrCnt_reg + 7'h01;
  end
  always_ff @(posedge clk) arrCnt_reg <= resetn ? arrCnt_next : 7'h00;
  property p_gain; w9 |=> pumpGainA == $past(regWrData[6:0])
    && pumpGainB == $past(regWrData[13:7]); endproperty
  a_gain: assert property (p_gain) else $error("gain wrong");
  property p_hold; !w9 |=> $stable(pumpGainA); endproperty
  a_hold: assert property (p_hold) else $error("gain moved");
  property p_off; w9 |=> offsetMagnitude == $past(regWrData[20:14])
    && offsetUpEn == $past(regWrData[21])
    && offsetDnEn == $past(regWrData[22]); endproperty
  a_off: assert property (p_off) else $error("offset wrong");
  property p_slip; wb |=> cycleSlipGuard == $past(regWrData[8:7]);
  endproperty
  a_slip: assert property (p_slip) else $error("slip wrong");
  property p_tri; wb |=> pumpTriState == !($past(regWrData[5])
    || $past(regWrData[6])); endproperty
  a_tri: assert property (p_tri) else $error("tri wrong");
  property p_up; wb ##1 ce |=> pumpUp == (($past(regWrData[4], 2)
    ? $past(pdDnRaw) : $past(pdUpRaw)) && $past(regWrData[5], 2));
  endproperty
  a_up: assert property (p_up) else $error("pump up wrong");
  property p_dn; wb ##1 ce |=> pumpDn == (($past(regWrData[4], 2)
    ? $past(pdUpRaw) : $past(pdDnRaw)) && $past(regWrData[6], 2));
  endproperty
  a_dn: assert property (p_dn) else $error("pump down wrong");
  property p_rise; $rose(lockFlag) |-> arrCnt_reg[6]; endproperty
  a_rise: assert property (p_rise) else $error("early lock");
  property p_dis; w7 && !regWrData[LD_ENABLE_BIT] |-> ##[1:2] !lockFlag;
  endproperty
  a_dis: assert property (p_dis) else $error("lock kept");
endmodule : lwpc_properties
bind lwpc_top lwpc_properties i_lwpc_properties (.clk, .resetn, .ce,
  .regWrEn, .regAddr, .regWrData, .refArrive, .divArrive, .pdUpRaw,
  .pdDnRaw, .pumpUp, .pumpDn, .pumpTriState, .pumpGainA, .pumpGainB,
  .offsetMagnitude, .offsetUpEn, .offsetDnEn, .cycleSlipGuard,
  .lockFlag);
`default_nettype wire

// ===== lwpc_top.sv
/*
  Lock window and pump control: register bank for lock detect and charge
  pump settings, the window generator and the lock flag.
  Assumes a decoded register write/read port from the serial interface
  and phase comparator arrival pulses synchronous to clk.
*/
//
// Contract
// R1: divider code 0..7 scales the window by 0.5,1,2,4,8,16,32,64 periods.
// R2: a two-bit speed code picks one of four timer periods, fastest at 00.
// R3: the window opens on whichever comparator input arrives first.
// R4: software picks a window above offset plus excursion, below a period.
// R5: bits 8:7 of phase detector control set the cycle slip threshold.
// R6: bit 4 of phase detector control inverts the up/down sense when set.
// R7: pump drive bits 5 and 6 both clear put the charge pump in tri-state.
// R8: gain codes at bits 6:0 and 13:7 set pump current in 20uA steps.
// R9: bits 20:14 set offset magnitude, bit 21 enables up, bit 22 down.
// R10: software sets only one offset direction enable at a time.
// R11: lock detect bit 6 picks the analogue window at 0, timer at 1.
// R12: lock rises after a programmed run of hits, drops on one miss.
// R13: the timer window is period times divider and closes on expiry.
`default_nettype none
module lwpc_top
  import lwpc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  // register port
  input  wire logic        regWrEn,
  input  wire logic [7:0]  regAddr,
  input  wire logic [23:0] regWrData,
  output var  logic [23:0] regRdData,
  // phase comparator
  input  wire logic        refArrive,
  input  wire logic        divArrive,
  input  wire logic        pdUpRaw,
  input  wire logic        pdDnRaw,
  // charge pump control
  output var  logic        pumpUp,
  output var  logic        pumpDn,
  output var  logic        pumpTriState,
  output var  logic [6:0]  pumpGainA,
  output var  logic [6:0]  pumpGainB,
  output var  logic [6:0]  offsetMagnitude,
  output var  logic        offsetUpEn,
  output var  logic        offsetDnEn,
  output var  logic [1:0]  cycleSlipGuard,
  // lock flag logic
  output var  logic        lockFlag
);
  import lwpc_pkg::*;

  // ***************************************************
  // register bank
  // ***************************************************
  logic [23:0] ldCtrl_reg, ldCtrl_next;
  logic [23:0] pump_reg, pump_next;
  logic [23:0] pdCtrl_reg, pdCtrl_next;
  logic [23:0] rd_reg, rd_next;
  logic        lock_reg, lock_next;

  always_comb begin
    ldCtrl_next = ldCtrl_reg;
    pump_next = pump_reg;
    pdCtrl_next = pdCtrl_reg;
    if (regWrEn) begin
      case (regAddr)
        ADDR_LOCK_DETECT_CONTROL: ldCtrl_next = regWrData;
        ADDR_PUMP_GAIN_AND_OFFSET: pump_next = regWrData;
        ADDR_PHASE_DETECTOR_CONTROL: pdCtrl_next = regWrData;
        default: ;
      endcase
    end
    case (regAddr)
      ADDR_LOCK_DETECT_CONTROL: rd_next = ldCtrl_reg;
      ADDR_PUMP_GAIN_AND_OFFSET: rd_next = pump_reg;
      ADDR_PHASE_DETECTOR_CONTROL: rd_next = pdCtrl_reg;
      ADDR_LOCK_STATUS: rd_next = 24'(lock_reg) << STATUS_LOCK_BIT;
      default: rd_next = 24'h000000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ldCtrl_reg <= RST_LOCK_DETECT_CONTROL;
      pump_reg <= RST_PUMP_GAIN_AND_OFFSET;
      pdCtrl_reg <= RST_PHASE_DETECTOR_CONTROL;
      rd_reg <= 24'h000000;
    end else if (ce) begin
      ldCtrl_reg <= ldCtrl_next;
      pump_reg <= pump_next;
      pdCtrl_reg <= pdCtrl_next;
      rd_reg <= rd_next;
    end
  end
  assign regRdData = rd_reg;

  // ***************************************************
  // field decode
  // ***************************************************
  logic [2:0] lockCode;
  logic       ldEnable;
  logic       ldDigital;
  logic [2:0] divCode;
  logic [1:0] speedCode;
  assign lockCode = ldCtrl_reg[LD_COUNT_LSB +: 3];
  assign ldEnable = ldCtrl_reg[LD_ENABLE_BIT];
  assign ldDigital = ldCtrl_reg[LD_DIGITAL_BIT]; // R11
  assign divCode = ldCtrl_reg[LD_DIV_LSB +: 3];
  assign speedCode = ldCtrl_reg[LD_SPEED_LSB +: 2];

  function automatic logic [3:0] timer_period(input logic [1:0] code);
    case (code) // R2
      2'h0: timer_period = TIMER_PERIOD_0;
      2'h1: timer_period = TIMER_PERIOD_1;
      2'h2: timer_period = TIMER_PERIOD_2;
      default: timer_period = TIMER_PERIOD_3;
    endcase
  endfunction : timer_period

  // period x (2^code / 2): code 0 is half a period
  logic [10:0] digWindow;
  logic [10:0] windowLen;
  assign digWindow = 11'({7'h00, timer_period(speedCode)} << divCode)
                     >> 1; // R1 R13
  assign windowLen = ldDigital ? digWindow : ANALOG_WINDOW_CYCLES; // R11

  // ***************************************************
  // window generator and lock flag
  // ***************************************************
  lwpc_win_t             win_reg, win_next;
  logic [10:0]           tick_reg, tick_next;
  logic [LOCK_COUNT_W-1:0] hits_reg, hits_next;
  logic [LOCK_COUNT_W-1:0] hitsNeeded;
  logic                  hit;
  logic                  miss;

  // four-bit shift amount: code 7 plus the base shift overflows three bits
  assign hitsNeeded = LOCK_COUNT_W'(1)
                      << (4'(lockCode) + 4'(LOCK_COUNT_SHIFT));

  always_comb begin
    win_next = win_reg;
    tick_next = tick_reg;
    hit = 1'b0;
    miss = 1'b0;
    case (win_reg)
      WIN_IDLE: begin
        tick_next = 11'h000;
        if (refArrive && divArrive) begin
          hit = 1'b1;
        end else if (refArrive) begin
          win_next = WIN_REF_FIRST; // R3
        end else if (divArrive) begin
          win_next = WIN_DIV_FIRST; // R3
        end
      end
      WIN_REF_FIRST, WIN_DIV_FIRST: begin
        tick_next = tick_reg + 11'h001;
        if ((win_reg == WIN_REF_FIRST && divArrive) ||
            (win_reg == WIN_DIV_FIRST && refArrive)) begin
          hit = 1'b1;
          win_next = WIN_IDLE;
        end else if (refArrive || divArrive) begin
          // same input twice: a miss, and the new edge opens afresh
          miss = 1'b1;
          tick_next = 11'h000;
        end else if (tick_next >= windowLen) begin
          miss = 1'b1; // R13
          win_next = WIN_IDLE;
        end
      end
      default: win_next = WIN_IDLE;
    endcase
    hits_next = hits_reg;
    lock_next = lock_reg;
    if (!ldEnable) begin
      hits_next = '0;
      lock_next = 1'b0;
    end else if (miss) begin
      hits_next = '0; // R12
      lock_next = 1'b0; // R12
    end else if (hit) begin
      if (hits_reg + LOCK_COUNT_W'(1) >= hitsNeeded) begin
        lock_next = 1'b1; // R12
        hits_next = hitsNeeded;
      end else begin
        hits_next = hits_reg + LOCK_COUNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      win_reg <= WIN_IDLE;
      tick_reg <= 11'h000;
      hits_reg <= '0;
      lock_reg <= 1'b0;
    end else if (ce) begin
      win_reg <= win_next;
      tick_reg <= tick_next;
      hits_reg <= hits_next;
      lock_reg <= lock_next;
    end
  end
  assign lockFlag = lock_reg;

  // ***************************************************
  // charge pump drive
  // ***************************************************
  logic upEn;
  logic dnEn;
  logic pol;
  logic pumpUp_reg, pumpUp_next;
  logic pumpDn_reg, pumpDn_next;
  assign upEn = pdCtrl_reg[PD_UP_ENABLE_BIT];
  assign dnEn = pdCtrl_reg[PD_DN_ENABLE_BIT];
  assign pol = pdCtrl_reg[PD_POLARITY_BIT];

  always_comb begin
    // inverted sense swaps which comparator output pumps up
    pumpUp_next = (pol ? pdDnRaw : pdUpRaw) & upEn; // R6
    pumpDn_next = (pol ? pdUpRaw : pdDnRaw) & dnEn; // R6
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pumpUp_reg <= 1'b0;
      pumpDn_reg <= 1'b0;
    end else if (ce) begin
      pumpUp_reg <= pumpUp_next;
      pumpDn_reg <= pumpDn_next;
    end
  end

  assign pumpUp = pumpUp_reg;
  assign pumpDn = pumpDn_reg;
  assign pumpTriState = ~upEn & ~dnEn; // R7
  assign pumpGainA = pump_reg[PG_GAIN_A_LSB +: 7]; // R8
  assign pumpGainB = pump_reg[PG_GAIN_B_LSB +: 7]; // R8
  assign offsetMagnitude = pump_reg[PG_OFFSET_LSB +: 7]; // R9
  assign offsetUpEn = pump_reg[PG_OFFSET_UP_BIT]; // R9
  // both enables set is passed through as written
  assign offsetDnEn = pump_reg[PG_OFFSET_DN_BIT]; // R9
  assign cycleSlipGuard = pdCtrl_reg[PD_SLIP_LSB +: 2]; // R5
endmodule : lwpc_top
`default_nettype wire

// ===== lwpc_top_tb.sv
/* self-checking bench for lwpc_top.
   assumes the lwpc_properties checker is bound in */
`default_nettype none
module lwpc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import lwpc_pkg::*;
  // ****************************************
  // stimulus and checks
  // ****************************************
  logic clk = 0, resetn = 0, ce = 1, regWrEn = 0;
  logic refArrive = 0, divArrive = 0, pdUpRaw = 0, pdDnRaw = 0;
  logic [7:0]  regAddr = 8'h00;
  logic [23:0] regWrData = 24'h000000, regRdData;
  logic pumpUp, pumpDn, pumpTriState, offsetUpEn, offsetDnEn, lockFlag;
  logic [6:0]  pumpGainA, pumpGainB, offsetMagnitude;
  logic [1:0]  cycleSlipGuard;
  logic [23:0] m [4] = '{default: 24'h000000};
  logic [7:0]  adr [4] = '{8'h07, 8'h09, 8'h0B, 8'h05};
  int fails = 0, compares = 0, seed = 71702;
  always #20 clk = ~clk;
  always @(posedge clk) {pdUpRaw, pdDnRaw} <= 2'($random(seed));
  lwpc_top i_lwpc_top (.clk, .resetn, .ce, .regWrEn, .regAddr,
    .regWrData, .regRdData, .refArrive, .divArrive, .pdUpRaw, .pdDnRaw,
    .pumpUp, .pumpDn, .pumpTriState, .pumpGainA, .pumpGainB,
    .offsetMagnitude, .offsetUpEn, .offsetDnEn, .cycleSlipGuard,
    .lockFlag);
  function int rnd(input int n);
    return int'($unsigned($random(seed)) % n);
  endfunction : rnd
  // window cycles: timer period 2,4,6,8 times divider 0.5..64
  function int win(input int s, input int d, input bit g);
    return g ? ((2 * (s + 1)) << d) >> 1 : 1;
  endfunction : win
  task check(input string n, input logic [23:0] s, input logic [23:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task conclude;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  task rd(input logic [7:0] a);
    @(posedge clk) regAddr <= a;
    repeat (2) @(posedge clk);
    #1;
  endtask : rd
  task wr(input int k, input logic [23:0] d);
    @(posedge clk);
    regWrEn <= 1;
    regAddr <= adr[k];
    regWrData <= d;
    @(posedge clk) regWrEn <= 0;
    if (k < 3) m[k] = d; // unmapped writes are dropped
    repeat (2) @(posedge clk);
    #1;
  endtask : wr
  task pair(input bit rf, input int d, input int w);
    @(posedge clk);
    if (d == 0 || rf) refArrive <= 1;
    if (d == 0 || !rf) divArrive <= 1;
    @(posedge clk);
    if (d == 0 || rf) refArrive <= 0;
    if (d == 0 || !rf) divArrive <= 0;
    if (d > 0) begin
      repeat (d - 1) @(posedge clk);
      if (rf) divArrive <= 1; else refArrive <= 1;
      @(posedge clk);
      if (rf) divArrive <= 0; else refArrive <= 0;
    end
    repeat (w + 4) @(posedge clk);
    #1;
  endtask : pair
  initial begin
    int s, d, w, k;
    bit g;
    logic [23:0] v;
    repeat (12) @(posedge clk);
    resetn <= 1;
    for (int i = 0; i < 4; i++) begin
      rd(adr[i]);
      check("reset read", regRdData, m[i]);
    end
    check("reset tri", pumpTriState, 1'b1);
    for (int i = 0; i < 40; i++) begin
      k = i < 8 ? i % 4 : rnd(4);
      v = i < 4 ? 24'hFFFFFF : i < 8 ? 24'h000000 : 24'($random(seed));
      if (k == 1 && v[21]) v[22] = 1'b0;
      wr(k, v);
      check("read", regRdData, m[k]);
      check("gain", {pumpGainB, pumpGainA}, m[1][13:0]);
      check("offset", {offsetDnEn, offsetUpEn, offsetMagnitude},
            m[1][22:14]);
      check("slip", cycleSlipGuard, m[2][8:7]);
      check("tri", pumpTriState, !(m[2][5] | m[2][6]));
    end
    // a write with the clock enable low must leave the pump gain and offset register as it was
    v = m[1];
    @(posedge clk) ce <= 0;
    wr(1, ~v);
    m[1] = v;
    @(posedge clk) ce <= 1;
    repeat (2) @(posedge clk);
    #1;
    check("frozen gain", {pumpGainB, pumpGainA}, v[13:0]);
    check("frozen offset", {offsetDnEn, offsetUpEn, offsetMagnitude},
          v[22:14]);
    for (int i = 0; i < 5; i++) begin
      g = i < 4;
      s = i % 4;
      d = rnd(5);
      w = win(s, d, g);
      wr(0, 24'((s << 10) | (d << 7) | (int'(g) << 6) | 8));
      for (int j = 0; j < 64; j++) begin
        if (j == 63) check("early", lockFlag, 1'b0);
        pair(j[0], j[1] ? w - 1 : rnd(w), w);
      end
      check("lock", lockFlag, 1'b1);
      rd(ADDR_LOCK_STATUS);
      check("status", regRdData[1], 1'b1);
      // an arrival one cycle past the window length counts as a miss
      if (g) pair(1'($random(seed)), w + 1, w);
      else wr(0, 24'h000000);
      check("drop", lockFlag, 1'b0);
    end
    conclude();
  end
endmodule : lwpc_top_tb
`default_nettype wire
